// [fsr_pkg.sv]
/*
  Package for the function status register block: register offsets,
  field positions, reset values, variant codes and power-state codes.
  Assumes a 32-bit APB register bus; all offsets are byte addresses.
*/
package fsr_pkg;

  // ----------------------------------------------------------------
  // Variants
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSR_VAR_SINGLE,
    FSR_VAR_DUAL_STRAP,
    FSR_VAR_DUAL_NV
  } fsr_variant_e;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] FSR_OFS_STATUS = 12'h000;
  localparam logic [11:0] FSR_OFS_CTRL   = 12'h004;
  localparam logic [11:0] FSR_OFS_SRC    = 12'h008;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int FSR_BIT_B_ACTIVE  = 10;
  localparam int FSR_BIT_FN1_AUX   = 9;
  localparam int FSR_BIT_B_PRESENT = 8;
  localparam int FSR_BIT_FN1_PM_LO = 6;
  localparam int FSR_BIT_A_ACTIVE  = 4;
  localparam int FSR_BIT_FN0_AUX   = 3;
  localparam int FSR_BIT_A_PRESENT = 2;
  localparam int FSR_BIT_FN0_PM_LO = 0;

  // Nonvolatile word bit positions
  localparam int FSR_NV_FUNC_DIS_BIT = 10;
  localparam int FSR_NV_PORT_DIS_BIT = 11;

  // Control register fields
  localparam int FSR_CTRL_FREEZE_BIT = 0;

  // ----------------------------------------------------------------
  // Power-state codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] FSR_PM_RESET_STATE = 2'h0;
  localparam logic [1:0] FSR_PM_D0_UNINIT   = 2'h1;
  localparam logic [1:0] FSR_PM_D0_ACTIVE   = 2'h2;
  localparam logic [1:0] FSR_PM_D3          = 2'h3;

  localparam logic [31:0] FSR_RST_STATUS = 32'h0000_0000;
  localparam logic        FSR_RST_FREEZE = 1'b0;

  localparam int FSR_SYNC_STAGES = 2;

endpackage

// [fsr_sync.sv]
/*
  Two-stage synchroniser for a bundle of level signals.
  Assumes inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/1ns
module fsr_sync
  import fsr_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule

// [fsr_top.sv]
/*
  Function status register block with its APB slave.
  Assumes: strap and S5 inputs are asynchronous levels; the config-space
  and power-state inputs and nonvolatile words come from clk_sys logic.
*/
`timescale 1ns/1ns
module fsr_top
  import fsr_pkg::*;
#(
  parameter fsr_variant_e VARIANT = FSR_VAR_DUAL_NV
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_a_strap,
  input wire logic port_b_strap,
  input wire logic sys_in_s5,
  input wire logic [15:0] nv_word_port_a,
  input wire logic [15:0] nv_word_port_b,
  input wire logic fn0_auxpower_pm_enable,
  input wire logic fn1_auxpower_pm_enable,
  input wire logic [1:0] fn0_pm_state_in,
  input wire logic [1:0] fn1_pm_state_in,
  output logic status_invalid
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pins_sync;

  fsr_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({sys_in_s5, port_b_strap, port_a_strap}),
    .sync_out(pins_sync)
  );

  logic strap_a;
  logic strap_b;
  logic in_s5;

  assign strap_a = pins_sync[0];
  assign strap_b = pins_sync[1];
  assign in_s5 = pins_sync[2];

  // ----------------------------------------------------------------
  // Field sources
  // ----------------------------------------------------------------
  function automatic logic port_active(input logic [15:0] nv_word, input logic present);
    port_active = !nv_word[FSR_NV_FUNC_DIS_BIT] && present;
  endfunction

  logic port_a_present_d;
  logic port_b_present_d;
  logic port_a_active_d;
  logic port_b_active_d;

  always_comb begin
    port_a_present_d = 1'b0;
    port_b_present_d = 1'b0;
    port_a_active_d = 1'b0;
    port_b_active_d = 1'b0;
    unique case (VARIANT)
      FSR_VAR_SINGLE: begin
        port_a_present_d = 1'b1;
        port_b_present_d = 1'b0;
      end
      FSR_VAR_DUAL_STRAP: begin
        port_a_present_d = strap_a;
        port_b_present_d = strap_b;
      end
      FSR_VAR_DUAL_NV: begin
        port_a_present_d = !nv_word_port_a[FSR_NV_PORT_DIS_BIT];
        port_b_present_d = strap_b;
        port_a_active_d = port_active(nv_word_port_a, port_a_present_d);
        port_b_active_d = port_active(nv_word_port_b, port_b_present_d);
      end
      default: begin
        port_a_present_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic freeze_q;
  logic invalid_q;

  always_comb begin
    status_d = FSR_RST_STATUS;
    status_d[FSR_BIT_B_ACTIVE] = port_b_active_d;
    status_d[FSR_BIT_B_PRESENT] = port_b_present_d;
    status_d[FSR_BIT_A_ACTIVE] = port_a_active_d;
    status_d[FSR_BIT_FN0_AUX] = fn0_auxpower_pm_enable;
    status_d[FSR_BIT_A_PRESENT] = port_a_present_d;
    status_d[FSR_BIT_FN0_PM_LO +: 2] = fn0_pm_state_in;
    if (VARIANT != FSR_VAR_SINGLE) begin
      status_d[FSR_BIT_FN1_AUX] = fn1_auxpower_pm_enable;
      status_d[FSR_BIT_FN1_PM_LO +: 2] = fn1_pm_state_in;
    end
  end

  // Hardware sources only; the bus never writes this register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_q <= FSR_RST_STATUS;
    end else if (!freeze_q) begin
      status_q <= status_d;
    end
  end

  // On the dual variants only, S5 marks the enables and power states as not valid
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      invalid_q <= 1'b0;
    end else begin
      invalid_q <= (VARIANT != FSR_VAR_SINGLE) && in_s5;
    end
  end

  assign status_invalid = invalid_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic access;
  logic hit_status;
  logic hit_ctrl;
  logic hit_src;
  logic mapped;

  assign access = psel && penable;
  assign hit_status = paddr == FSR_OFS_STATUS;
  assign hit_ctrl = paddr == FSR_OFS_CTRL;
  assign hit_src = paddr == FSR_OFS_SRC;
  assign mapped = hit_status || hit_ctrl || hit_src;
  assign pready = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && !hit_ctrl));

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      freeze_q <= FSR_RST_FREEZE;
    end else if (access && pwrite && hit_ctrl && pstrb[0]) begin
      freeze_q <= pwdata[FSR_CTRL_FREEZE_BIT];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (access && !pwrite) begin
      if (hit_status) begin
        prdata = status_q;
      end else if (hit_ctrl) begin
        prdata[FSR_CTRL_FREEZE_BIT] = freeze_q;
      end else if (hit_src) begin
        prdata = {29'h0000_0000, invalid_q, strap_b, strap_a};
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_b_active;
    @(posedge clk_sys) disable iff (!reset_n)
    status_q[FSR_BIT_B_ACTIVE] |-> status_q[FSR_BIT_B_PRESENT];
  endproperty
  a_b_active: assert property (p_b_active) else $error("port b active without present");

  property p_a_active;
    @(posedge clk_sys) disable iff (!reset_n)
    status_q[FSR_BIT_A_ACTIVE] |-> status_q[FSR_BIT_A_PRESENT];
  endproperty
  a_a_active: assert property (p_a_active) else $error("port a active without present");

  property p_fn1_aux;
    @(posedge clk_sys) disable iff (!reset_n)
    !freeze_q |=> status_q[FSR_BIT_FN1_AUX] == ((VARIANT != FSR_VAR_SINGLE) && $past(fn1_auxpower_pm_enable));
  endproperty
  a_fn1_aux: assert property (p_fn1_aux) else $error("fn1 aux shadow wrong");

  property p_b_present;
    @(posedge clk_sys) disable iff (!reset_n)
    (!freeze_q && VARIANT == FSR_VAR_SINGLE) |=> !status_q[FSR_BIT_B_PRESENT];
  endproperty
  a_b_present: assert property (p_b_present) else $error("port b present on single variant");

  property p_fn1_pm;
    @(posedge clk_sys) disable iff (!reset_n)
    (!freeze_q && VARIANT != FSR_VAR_SINGLE) |=> status_q[7:6] == $past(fn1_pm_state_in);
  endproperty
  a_fn1_pm: assert property (p_fn1_pm) else $error("fn1 power state wrong");

  property p_fn0_aux;
    @(posedge clk_sys) disable iff (!reset_n)
    !freeze_q |=> status_q[FSR_BIT_FN0_AUX] == $past(fn0_auxpower_pm_enable);
  endproperty
  a_fn0_aux: assert property (p_fn0_aux) else $error("fn0 aux shadow wrong");

  property p_a_strap;
    @(posedge clk_sys) disable iff (!reset_n)
    (!freeze_q && VARIANT == FSR_VAR_DUAL_STRAP) |=> status_q[FSR_BIT_A_PRESENT] == $past(strap_a);
  endproperty
  a_a_strap: assert property (p_a_strap) else $error("port a strap not followed");

  property p_a_nv;
    @(posedge clk_sys) disable iff (!reset_n)
    (!freeze_q && VARIANT == FSR_VAR_DUAL_NV) |=>
      status_q[FSR_BIT_A_PRESENT] == !$past(nv_word_port_a[FSR_NV_PORT_DIS_BIT]);
  endproperty
  a_a_nv: assert property (p_a_nv) else $error("port a present not from nv disable");

  property p_fn0_pm;
    @(posedge clk_sys) disable iff (!reset_n)
    !freeze_q |=> status_q[1:0] == $past(fn0_pm_state_in);
  endproperty
  a_fn0_pm: assert property (p_fn0_pm) else $error("fn0 power state wrong");

  property p_s5;
    @(posedge clk_sys) disable iff (!reset_n)
    (VARIANT != FSR_VAR_SINGLE) && in_s5 |=> status_invalid;
  endproperty
  a_s5: assert property (p_s5) else $error("s5 not flagged invalid");

  property p_ro;
    @(posedge clk_sys) disable iff (!reset_n)
    freeze_q && $past(freeze_q) |-> $stable(status_q);
  endproperty
  a_ro: assert property (p_ro) else $error("status changed while held");

  property p_b_active_nv;
    @(posedge clk_sys) disable iff (!reset_n)
    (!freeze_q && VARIANT == FSR_VAR_DUAL_NV) |=>
      status_q[FSR_BIT_B_ACTIVE] == (!$past(nv_word_port_b[FSR_NV_FUNC_DIS_BIT]) && $past(strap_b));
  endproperty
  a_b_active_nv: assert property (p_b_active_nv) else $error("port b active value wrong");

  property p_a_active_nv;
    @(posedge clk_sys) disable iff (!reset_n)
    (!freeze_q && VARIANT == FSR_VAR_DUAL_NV) |=>
      status_q[FSR_BIT_A_ACTIVE] ==
      (!$past(nv_word_port_a[FSR_NV_FUNC_DIS_BIT]) && !$past(nv_word_port_a[FSR_NV_PORT_DIS_BIT]));
  endproperty
  a_a_active_nv: assert property (p_a_active_nv) else $error("port a active value wrong");

  property p_active_off;
    @(posedge clk_sys) disable iff (!reset_n)
    (VARIANT != FSR_VAR_DUAL_NV) |-> !status_q[FSR_BIT_A_ACTIVE] && !status_q[FSR_BIT_B_ACTIVE];
  endproperty
  a_active_off: assert property (p_active_off) else $error("active bit set on variant without it");

  property p_b_strap;
    @(posedge clk_sys) disable iff (!reset_n)
    (!freeze_q && VARIANT != FSR_VAR_SINGLE) |=> status_q[FSR_BIT_B_PRESENT] == $past(strap_b);
  endproperty
  a_b_strap: assert property (p_b_strap) else $error("port b strap not followed");

  property p_fn1_aux_single;
    @(posedge clk_sys) disable iff (!reset_n)
    (VARIANT == FSR_VAR_SINGLE) |-> !status_q[FSR_BIT_FN1_AUX];
  endproperty
  a_fn1_aux_single: assert property (p_fn1_aux_single) else $error("fn1 aux set on single variant");

  property p_fn1_pm_single;
    @(posedge clk_sys) disable iff (!reset_n)
    (VARIANT == FSR_VAR_SINGLE) |-> status_q[7:6] == FSR_PM_RESET_STATE;
  endproperty
  a_fn1_pm_single: assert property (p_fn1_pm_single) else $error("fn1 state set on single variant");

  property p_a_single;
    @(posedge clk_sys) disable iff (!reset_n)
    (!freeze_q && VARIANT == FSR_VAR_SINGLE) |=> status_q[FSR_BIT_A_PRESENT];
  endproperty
  a_a_single: assert property (p_a_single) else $error("port a present clear on single variant");

  property p_pm_reset;
    @(posedge clk_sys)
    !reset_n |=> status_q[1:0] == FSR_PM_RESET_STATE && status_q[7:6] == FSR_PM_RESET_STATE;
  endproperty
  a_pm_reset: assert property (p_pm_reset) else $error("power state not reset");

  property p_s5_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    !in_s5 |=> !status_invalid;
  endproperty
  a_s5_clear: assert property (p_s5_clear) else $error("invalid flag without s5");

  property p_s5_single;
    @(posedge clk_sys) disable iff (!reset_n)
    (VARIANT == FSR_VAR_SINGLE) |-> !status_invalid;
  endproperty
  a_s5_single: assert property (p_s5_single) else $error("invalid flag on single variant");

  property p_wr_refused;
    @(posedge clk_sys) disable iff (!reset_n)
    (access && pwrite && !hit_ctrl) |-> pslverr;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("read-only write not refused");

  property p_wr_no_effect;
    @(posedge clk_sys) disable iff (!reset_n)
    (access && pwrite && !hit_ctrl) |=> freeze_q == $past(freeze_q);
  endproperty
  a_wr_no_effect: assert property (p_wr_no_effect) else $error("refused write changed state");

  property p_reserved;
    @(posedge clk_sys) disable iff (!reset_n)
    status_q[31:11] == 21'h00_0000 && !status_q[5];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bit set");

  property p_rd_idle;
    @(posedge clk_sys) disable iff (!reset_n)
    !(access && !pwrite) |-> prdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read access");

  c_read_status: cover property (@(posedge clk_sys) access && !pwrite && hit_status);
  c_both_active: cover property (@(posedge clk_sys) status_q[FSR_BIT_A_ACTIVE] && status_q[FSR_BIT_B_ACTIVE]);
  c_refused: cover property (@(posedge clk_sys) access && pslverr);
  c_freeze: cover property (@(posedge clk_sys) access && pwrite && hit_ctrl && pwdata[0]);
  c_s5: cover property (@(posedge clk_sys) status_invalid);

endmodule

// [test_function_status_register.sv]
/*
  Self-checking testbench for the function status register block.
  Assumes fsr_pkg and fsr_top are compiled first; default variant is used.
*/
`timescale 1ns/1ns
module test_function_status_register
  import fsr_pkg::*;
;
  typedef struct packed {logic rd; logic [31:0] d; logic e;} fsr_exp_s;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, status_invalid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, snap;
  logic [3:0] pstrb;
  logic port_a_strap, port_b_strap, sys_in_s5, aux0, aux1;
  logic [15:0] nv_a, nv_b, rnd;
  logic [1:0] pm0, pm1;
  integer err_total, tests_run;
  fsr_exp_s exq[$];
  fsr_exp_s cur;

  fsr_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_strap(port_a_strap), .port_b_strap(port_b_strap), .sys_in_s5(sys_in_s5),
    .nv_word_port_a(nv_a), .nv_word_port_b(nv_b), .fn0_auxpower_pm_enable(aux0),
    .fn1_auxpower_pm_enable(aux1), .fn0_pm_state_in(pm0), .fn1_pm_state_in(pm1),
    .status_invalid(status_invalid));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] exp_status();
    logic [31:0] v;
    v = 32'h0000_0000;
    v[10] = ~nv_b[10] & port_b_strap;
    v[9] = aux1;
    v[8] = port_b_strap;
    v[7:6] = pm1;
    v[4] = ~nv_a[10] & ~nv_a[11];
    v[3] = aux0;
    v[2] = ~nv_a[11];
    v[1:0] = pm0;
    return v;
  endfunction

  task check_word(input string name, input logic [31:0] e, input logic [31:0] s);
    tests_run = tests_run + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", name, e, s);
    end
  endtask

  task check_bit(input string name, input logic e, input logic s);
    tests_run = tests_run + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("ERROR %s expected %b seen %b", name, e, s);
    end
  endtask

  // APB master: setup, then access held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ed, input logic ee);
    integer n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exq.push_back('{~w & ~ee, ed, ee});
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check_bit("pready", 1'b1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task new_inputs(input logic [1:0] code);
    @(posedge clk_sys);
    rnd = lfsr(rnd);
    port_a_strap <= rnd[0];
    port_b_strap <= rnd[1];
    aux0 <= rnd[2];
    aux1 <= rnd[5];
    nv_a <= rnd;
    nv_b <= {rnd[7:0], rnd[15:8]};
    pm0 <= code;
    pm1 <= ~code;
    repeat (4) @(posedge clk_sys);
  endtask

  task end_of_test();
    $display("Checks made %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Monitor: compares each completed access with the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exq.size() == 0) check_bit("unexpected_access", 1'b0, 1'b1);
      else begin
        cur = exq.pop_front();
        if (cur.rd) check_word("prdata", cur.d, prdata);
        check_bit("pslverr", cur.e, pslverr);
      end
    end
  end

  initial begin
    repeat (4000) @(posedge clk_sys);
    $display("ERROR watchdog expected done seen hang");
    err_total = err_total + 1;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    {port_a_strap, port_b_strap, sys_in_s5, aux0, aux1, nv_a, nv_b, pm0, pm1} = '0;
    err_total = 0;
    tests_run = 0;
    rnd = 16'h0014;
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(1'b0, FSR_OFS_STATUS, 32'h0, 32'h0000_0014, 1'b0);
    apb(1'b0, FSR_OFS_CTRL, 32'h0, 32'h0000_0000, 1'b0);
    $display("Test reset done");
    for (int i = 0; i < 12; i++) begin
      new_inputs(i[1:0]);
      apb(1'b0, FSR_OFS_STATUS, 32'h0, exp_status(), 1'b0);
      apb(1'b1, FSR_OFS_STATUS, {rnd, ~rnd}, 32'h0, 1'b1);
      apb(1'b0, FSR_OFS_STATUS, 32'h0, exp_status(), 1'b0);
      apb(1'b0, FSR_OFS_SRC, 32'h0, {30'h0, port_b_strap, port_a_strap}, 1'b0);
    end
    $display("Test random status done");
    apb(1'b1, FSR_OFS_CTRL, 32'h0000_0001, 32'h0, 1'b0);
    snap = exp_status();
    new_inputs(2'h3);
    apb(1'b0, FSR_OFS_STATUS, 32'h0, snap, 1'b0);
    apb(1'b1, FSR_OFS_CTRL, 32'h0000_0000, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys);
    apb(1'b0, FSR_OFS_STATUS, 32'h0, exp_status(), 1'b0);
    $display("Test freeze done");
    @(posedge clk_sys);
    sys_in_s5 <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check_bit("status_invalid", 1'b1, status_invalid);
    apb(1'b0, FSR_OFS_SRC, 32'h0, {29'h0, 1'b1, port_b_strap, port_a_strap}, 1'b0);
    sys_in_s5 <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check_bit("status_invalid", 1'b0, status_invalid);
    $display("Test sleep flag done");
    apb(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
    apb(1'b1, FSR_OFS_SRC, 32'hFFFF_FFFF, 32'h0, 1'b1);
    apb(1'b0, FSR_OFS_STATUS, 32'h0, exp_status(), 1'b0);
    repeat (2) @(posedge clk_sys);
    $display("Test refusals done");
    end_of_test();
  end
endmodule
